// ===== core/icmf_framer.sv
// framer top: passes image words, appends check and metadata records
// assumes one clock, an image stream in, a ready-driven link out
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module icmf_framer (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // acquisition and frame metadata from the pipeline
  input wire logic ACQ_RUN_IN,
  input wire logic FRAME_START_IN,
  input wire logic EXPOSURE_END_IN,
  input wire logic [7:0] LINE_STATE_IN,
  input wire icmf_pkg::icmf_meta_type META_IN,
  // image stream in
  input wire logic PIX_VALID_IN,
  input wire logic [31:0] PIX_DATA_IN,
  input wire logic PIX_LAST_IN,
  output logic PIX_READY_OUT,
  // framed payload out
  output logic OUT_VALID_OUT,
  output icmf_pkg::icmf_beat_type OUT_BEAT_OUT,
  input wire logic OUT_READY_IN,
  // interrupt
  output logic IRQ_OUT
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] line_s1_r;  // first stage, read only by second
  logic [7:0] line_s2_r;  // synchronised line states

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      line_s1_r <= 8'h00;
      line_s2_r <= 8'h00;
    end else begin
      line_s1_r <= LINE_STATE_IN;
      line_s2_r <= line_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // crc function
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? icmf_pkg::CRC_POLY : 32'h0000_0000);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic attach_on_r;               // metadata_attach_on
  logic [3:0] pick_r;              // record_type_pick
  logic [14:0] incl_r;             // record_include_flag per record
  logic [1:0] gain_pick_r;         // gain_channel_pick
  logic offset_pick_r;             // offset_level_channel_pick
  logic [2:0] stat_r;              // sticky events
  logic [2:0] ien_r;               // interrupt enables
  logic [31:0] crc_last_r;         // check of last frame
  logic [31:0] fnum_last_r;        // number of last frame
  logic [31:0] prdata_r;           // read data

  wire wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  // read data is captured in the setup cycle so that it stands at the access edge
  wire rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  wire hit_ctrl = PADDR_IN == icmf_pkg::ADDR_CTRL;
  wire hit_pick = PADDR_IN == icmf_pkg::ADDR_PICK;
  wire hit_incl = PADDR_IN == icmf_pkg::ADDR_INCL;
  wire hit_gainp = PADDR_IN == icmf_pkg::ADDR_GAINP;
  wire hit_blkp = PADDR_IN == icmf_pkg::ADDR_BLKP;
  wire hit_stat = PADDR_IN == icmf_pkg::ADDR_STAT;
  wire hit_clr = PADDR_IN == icmf_pkg::ADDR_CLR;
  wire hit_ien = PADDR_IN == icmf_pkg::ADDR_IEN;
  wire hit_crc = PADDR_IN == icmf_pkg::ADDR_CRC;
  wire hit_fnum = PADDR_IN == icmf_pkg::ADDR_FNUM;
  wire hit_any = hit_ctrl | hit_pick | hit_incl | hit_gainp | hit_blkp | hit_stat |
                 hit_clr | hit_ien | hit_crc | hit_fnum;
  // include writes are dropped while acquisition runs
  wire incl_wr = wr_en && hit_incl && !ACQ_RUN_IN;
  wire incl_refused = wr_en && hit_incl && ACQ_RUN_IN;
  wire pick_ok = pick_r < 4'(icmf_pkg::NUM_REC);

  // next include vector: image and check bits forced on
  logic [14:0] incl_nxt;
  always_comb begin
    incl_nxt = incl_r;
    if (incl_wr && pick_ok) begin
      incl_nxt[pick_r] = PWDATA_IN[0];
    end
    incl_nxt[icmf_pkg::REC_IMAGE] = 1'b1;
    incl_nxt[icmf_pkg::REC_CHECK] = 1'b1;
  end

  // read mux
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, ACQ_RUN_IN, attach_on_r} :
    hit_pick ? {28'h0, pick_r} :
    hit_incl ? {31'h0, pick_ok & incl_r[pick_r]} :
    hit_gainp ? {30'h0, gain_pick_r} :
    hit_blkp ? {31'h0, offset_pick_r} :
    hit_stat ? {29'h0, stat_r} :
    hit_ien ? {29'h0, ien_r} :
    hit_crc ? crc_last_r :
    hit_fnum ? fnum_last_r : 32'h0000_0000;

  // event pulses
  logic frame_done;
  wire [2:0] evt_set = {META_IN.serial_ovr & FRAME_START_IN, incl_refused, frame_done};
  wire [2:0] evt_clr = (wr_en && hit_clr) ? PWDATA_IN[2:0] : 3'h0;

  // control registers
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      attach_on_r <= 1'b0;
      pick_r <= 4'h0;
      incl_r <= icmf_pkg::INCL_RESET[14:0];
      gain_pick_r <= 2'h0;
      offset_pick_r <= 1'b0;
      ien_r <= 3'h0;
      stat_r <= 3'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_en && hit_ctrl && !ACQ_RUN_IN) attach_on_r <= PWDATA_IN[0];
      if (wr_en && hit_pick) pick_r <= PWDATA_IN[3:0];
      if (wr_en && hit_gainp) gain_pick_r <= PWDATA_IN[1:0];
      if (wr_en && hit_blkp) offset_pick_r <= PWDATA_IN[0];
      if (wr_en && hit_ien) ien_r <= PWDATA_IN[2:0];
      incl_r <= incl_nxt;
      // set wins over clear
      stat_r <= (stat_r & ~evt_clr) | evt_set;
      // zero wait states: the access edge must already see the word
      if (rd_setup) prdata_r <= rd_mux;
    end
  end

  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit_any;
  assign IRQ_OUT = |(stat_r & ien_r);

  // ----------------------------------------------------------------
  // per frame capture
  // ----------------------------------------------------------------
  icmf_pkg::icmf_meta_type meta_r;   // metadata of frame in flight
  logic [7:0] lines_r;               // line snapshot at exposure end
  logic [14:0] incl_frame_r;         // include set of frame in flight
  logic attach_frame_r;              // attach setting of frame in flight

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      meta_r <= '0;
      lines_r <= 8'h00;
      incl_frame_r <= icmf_pkg::INCL_RESET[14:0];
      attach_frame_r <= 1'b0;
    end else begin
      if (FRAME_START_IN) begin
        meta_r <= META_IN;
        incl_frame_r <= incl_r;
        attach_frame_r <= attach_on_r;
      end
      if (EXPOSURE_END_IN) lines_r <= line_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // framing state machine
  // ----------------------------------------------------------------
  typedef enum {ST_IMAGE, ST_REC} icmf_state_type;
  icmf_state_type state_r;
  logic [3:0] rec_r;     // record being sent
  logic [1:0] sub_r;     // word within multiword record
  logic [31:0] crc_r;

  // last word index per record and record payload
  function automatic logic [1:0] rec_words(input logic [3:0] r);
    return (r == 4'(icmf_pkg::REC_TIME) || r == 4'(icmf_pkg::REC_SERIAL)) ? 2'd1 : 2'd0;
  endfunction

  // next enabled record after r, 15 when none
  function automatic logic [3:0] next_rec(input logic [3:0] r, input logic [14:0] en,
                                          input logic att);
    logic [3:0] n;
    n = 4'hF;
    for (int i = 14; i >= 1; i--) begin
      if (4'(i) > r && en[i] && (att || i == 1)) n = 4'(i);
    end
    return n;
  endfunction

  wire [31:0] gain_sel = gain_pick_r == 2'd0 ? meta_r.gain_all :
                         gain_pick_r == 2'd1 ? meta_r.gain_r :
                         gain_pick_r == 2'd2 ? meta_r.gain_g : meta_r.gain_b;

  logic [31:0] rec_data;
  always_comb begin
    rec_data = 32'h0000_0000;
    unique case (rec_r)
      4'(icmf_pkg::REC_CHECK): rec_data = crc_r;
      4'(icmf_pkg::REC_FNUM): rec_data = meta_r.frame_num;
      4'(icmf_pkg::REC_LEFT): rec_data = {16'h0, meta_r.left};
      4'(icmf_pkg::REC_TOP): rec_data = {16'h0, meta_r.top};
      4'(icmf_pkg::REC_SPANX): rec_data = {16'h0, meta_r.span_x};
      4'(icmf_pkg::REC_SPANY): rec_data = {16'h0, meta_r.span_y};
      4'(icmf_pkg::REC_SHUTTER): rec_data = meta_r.shutter;
      4'(icmf_pkg::REC_GAIN): rec_data = gain_sel;
      4'(icmf_pkg::REC_BLACK): rec_data = meta_r.black;
      4'(icmf_pkg::REC_PIXEL): rec_data = {28'h0, meta_r.pix};
      4'(icmf_pkg::REC_TIME): rec_data = sub_r[0] ? meta_r.tstamp[63:32]
                                                 : meta_r.tstamp[31:0];
      4'(icmf_pkg::REC_STEP): rec_data = {24'h0, meta_r.step};
      4'(icmf_pkg::REC_SERIAL): rec_data = sub_r[0] ? meta_r.serial_data
          : {23'h0, meta_r.serial_ovr, meta_r.serial_len};
      4'(icmf_pkg::REC_LINES): rec_data = {24'h0, lines_r};
      default: rec_data = 32'h0000_0000;
    endcase
  end

  icmf_pkg::icmf_beat_type beat_r;
  logic valid_r;
  wire out_free = !valid_r || OUT_READY_IN;
  assign PIX_READY_OUT = (state_r == ST_IMAGE) && out_free;
  wire pix_take = PIX_VALID_IN && PIX_READY_OUT;
  wire rec_fire = (state_r == ST_REC) && out_free;
  wire rec_end = sub_r == rec_words(rec_r);
  wire [3:0] rec_after = next_rec(rec_r, incl_frame_r, attach_frame_r);
  assign frame_done = rec_fire && rec_end && rec_after == 4'hF;

  // sequence: image words, check record, then enabled records in order
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= ST_IMAGE;
      rec_r <= 4'h0;
      sub_r <= 2'h0;
      crc_r <= icmf_pkg::CRC_INIT;
      valid_r <= 1'b0;
      beat_r <= '0;
      crc_last_r <= 32'h0000_0000;
      fnum_last_r <= 32'h0000_0000;
    end else begin
      if (OUT_READY_IN) valid_r <= 1'b0;
      unique case (state_r)
        ST_IMAGE: begin
          if (pix_take) begin
            valid_r <= 1'b1;
            beat_r <= '{data: PIX_DATA_IN, tag: 4'(icmf_pkg::REC_IMAGE), last: 1'b0};
            crc_r <= crc_word(crc_r, PIX_DATA_IN);
            if (PIX_LAST_IN) begin
              state_r <= ST_REC;
              rec_r <= 4'(icmf_pkg::REC_CHECK);
              sub_r <= 2'h0;
            end
          end
        end
        ST_REC: begin
          if (rec_fire) begin
            valid_r <= 1'b1;
            beat_r <= '{data: rec_data, tag: rec_r, last: rec_end && rec_after == 4'hF};
            if (!rec_end) begin
              sub_r <= sub_r + 2'd1;
            end else if (rec_after != 4'hF) begin
              rec_r <= rec_after;
              sub_r <= 2'h0;
            end else begin
              state_r <= ST_IMAGE;
              crc_last_r <= crc_r;
              fnum_last_r <= meta_r.frame_num;
              crc_r <= icmf_pkg::CRC_INIT;
            end
          end
        end
      endcase
    end
  end

  assign OUT_VALID_OUT = valid_r;
  assign OUT_BEAT_OUT = beat_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // include and attach flags: fixed records, freezing and selector writes
  a_image_forced: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    incl_r[1:0] == 2'b11) else $error("image or check flag cleared");
  a_frozen_incl: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ACQ_RUN_IN && wr_en && hit_incl |=> $stable(incl_r))
    else $error("include changed during acquisition");
  a_attach_frozen: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ACQ_RUN_IN |=> $stable(attach_on_r)) else $error("attach changed during acquisition");
  a_incl_write: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    incl_wr && pick_r > 4'd1 && pick_r < 4'd15 |=> incl_r[$past(pick_r)] == $past(PWDATA_IN[0]))
    else $error("include write lost");

  // record sequence on the link
  a_no_attach: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    valid_r && !attach_frame_r |-> beat_r.tag <= 4'd1)
    else $error("record sent with attach off");
  a_check_first: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    pix_take && PIX_LAST_IN |=> state_r == ST_REC && rec_r == 4'd1)
    else $error("check record not next");
  a_rec_order: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rec_fire && rec_end && rec_after != 4'hF |=> rec_r > $past(rec_r))
    else $error("records out of order");
  // the final beat carries last and raises the frame event at once
  a_last_done: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    frame_done |=> OUT_BEAT_OUT.last && stat_r[icmf_pkg::STAT_FRAME_BIT])
    else $error("frame end not marked");
  // a stalled beat must stand unchanged until the host takes it
  a_stall_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    valid_r && !OUT_READY_IN |=> valid_r && $stable(beat_r))
    else $error("beat dropped while stalled");

  // per frame capture
  a_meta_latch: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    FRAME_START_IN |=> meta_r == $past(META_IN)) else $error("metadata not latched");
  a_lines_snap: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    EXPOSURE_END_IN |=> lines_r == $past(line_s2_r)) else $error("line snapshot lost");

  // interrupt follows an enabled frame event unless the enable is being rewritten
  a_irq_event: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    frame_done && ien_r[icmf_pkg::STAT_FRAME_BIT] && !(wr_en && hit_ien) |=> IRQ_OUT)
    else $error("interrupt missing after frame");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_frame_end: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN) frame_done);
  c_refused: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN) incl_refused);
  c_stall: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    valid_r && !OUT_READY_IN);
  // a frame that carried optional records
  c_attach_frame: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    frame_done && attach_frame_r);
  // the last record of the enumeration went out
  c_lines_rec: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rec_fire && rec_r == 4'(icmf_pkg::REC_LINES));
endmodule // icmf_framer

// ===== core/icmf_pkg.sv
// package for the image metadata framer: register map, record ids, carriers
// assumes a 32-bit APB master and one 50 MHz clock domain
package icmf_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;     // attach on, acquisition status
  localparam logic [7:0] ADDR_PICK = 8'h04;     // record type selector
  localparam logic [7:0] ADDR_INCL = 8'h08;     // include flag of selected record
  localparam logic [7:0] ADDR_GAINP = 8'h0C;    // gain channel pick
  localparam logic [7:0] ADDR_BLKP = 8'h10;     // black level channel pick
  localparam logic [7:0] ADDR_STAT = 8'h14;     // sticky event status, read only
  localparam logic [7:0] ADDR_CLR = 8'h18;      // write one to clear status
  localparam logic [7:0] ADDR_IEN = 8'h1C;      // interrupt enable
  localparam logic [7:0] ADDR_CRC = 8'h20;      // last frame check value
  localparam logic [7:0] ADDR_FNUM = 8'h24;     // last frame number
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ATTACH_BIT = 0;
  localparam int CTRL_ACQ_BIT = 1;
  localparam logic [15:0] INCL_RESET = 16'h0003; // image and check always on
  localparam int STAT_FRAME_BIT = 0;             // a frame finished
  localparam int STAT_FROZEN_BIT = 1;            // include write refused
  localparam int STAT_OVR_BIT = 2;               // serial overrun seen
  localparam int NUM_REC = 15;
  localparam int NUM_EVT = 3;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam int SER_BYTES = 4;

  // record order on the link and in the selector
  typedef enum logic [3:0] {
    REC_IMAGE, REC_CHECK, REC_FNUM, REC_LEFT, REC_TOP, REC_SPANX, REC_SPANY,
    REC_SHUTTER, REC_GAIN, REC_BLACK, REC_PIXEL, REC_TIME, REC_STEP,
    REC_SERIAL, REC_LINES
  } icmf_rec_type;

  // pixel layouts
  typedef enum logic [3:0] {
    PIX_MONO8, PIX_MONO12P, PIX_MONO16, PIX_RGB8P, PIX_YUV422P,
    PIX_BGR8, PIX_BRG8, PIX_BGB8, PIX_BBG8, PIX_YCBCR_CBYCRY
  } icmf_pix_type;

  // metadata describing one frame, captured at its start
  typedef struct packed {
    logic [31:0] frame_num;
    logic [15:0] left;
    logic [15:0] top;
    logic [15:0] span_x;
    logic [15:0] span_y;
    logic [31:0] shutter;
    logic [31:0] gain_all;
    logic [31:0] gain_r;
    logic [31:0] gain_g;
    logic [31:0] gain_b;
    logic [31:0] black;
    icmf_pix_type pix;
    logic [63:0] tstamp;
    logic [7:0] step;
    logic [31:0] serial_data;
    logic [7:0] serial_len;
    logic serial_ovr;
  } icmf_meta_type;

  // one stream beat
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] tag;
    logic last;
  } icmf_beat_type;
endpackage

// ===== verif/icmf_host_model.sv
// host side of the framed payload link: takes beats, may stall
// assumes the framer drives valid and beat, holding them until ready
`timescale 1ns/1ps
module icmf_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // stall mode, ready only one cycle in four when high
  input wire logic slow_in,
  // framed payload
  input wire logic valid_in,
  input wire icmf_pkg::icmf_beat_type beat_in,
  output logic ready_out
);
  // ------------------------------------------------------------
  // acceptance
  // ------------------------------------------------------------
  icmf_pkg::icmf_beat_type rx_q[$]; // beats taken, oldest first
  logic [1:0] cnt_r; // stall pattern phase

  // ready changes only after an edge; a beat counts when both were high
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 2'd0;
      ready_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'd1;
      ready_out <= !slow_in || (cnt_r == 2'd3);
      if (valid_in && ready_out) begin
        rx_q.push_back(beat_in);
      end
    end
  end
endmodule // icmf_host_model

// ===== verif/testbench.sv
// bench for the framer: apb register tests and framed payload checks
// assumes the host model beside it and the package constants
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, rst_n, psel, pen, pwr, pready, perr, acq, fs, ee;
  logic pv, plast, prdy, ovalid, oready, irq, slow;
  logic [7:0] paddr, lines;
  logic [31:0] pwd, prd, pd, crc;
  icmf_pkg::icmf_meta_type meta;
  icmf_pkg::icmf_beat_type obeat;
  icmf_pkg::icmf_beat_type exp_q[$]; // expected beats
  int n_mismatch, checked;

  icmf_framer dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .ACQ_RUN_IN(acq), .FRAME_START_IN(fs),
    .EXPOSURE_END_IN(ee), .LINE_STATE_IN(lines), .META_IN(meta), .PIX_VALID_IN(pv),
    .PIX_DATA_IN(pd), .PIX_LAST_IN(plast), .PIX_READY_OUT(prdy), .OUT_VALID_OUT(ovalid),
    .OUT_BEAT_OUT(obeat), .OUT_READY_IN(oready), .IRQ_OUT(irq));
  icmf_host_model host_u (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
    .valid_in(ovalid), .beat_in(obeat), .ready_out(oready));

  // free running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // counts and verdict, the only place the run ends
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // word compare
  task automatic cmp32(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // beat compare
  task automatic cmp_beat(input icmf_pkg::icmf_beat_type ex, input icmf_pkg::icmf_beat_type got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected beat expected %h seen %h", ex, got);
    end
  endtask

  // one apb transfer: setup, access held until pready, data taken at that edge,
  // then one idle edge so that back to back calls never drive twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= wd;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    err = perr;
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex,
                        input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp32(nm, ex, rd);
    cmp32("slverr", {31'h0000_0000, eerr}, {31'h0000_0000, err});
  endtask

  function automatic icmf_pkg::icmf_beat_type bt(logic [31:0] dd, int t, logic l);
    bt.data = dd;
    bt.tag = 4'(t);
    bt.last = l;
  endfunction

  // frame start then n image words; metadata moves on right after start
  task automatic send_frame(input int n);
    logic [31:0] w;
    crc = icmf_pkg::CRC_INIT;
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
    meta.frame_num <= meta.frame_num + 32'h0000_0001;
    for (int i = 0; i < n; i++) begin
      w = 32'hA5C3_0000 + 32'(i * 7);
      pv <= 1'b1;
      pd <= w;
      plast <= (i == n - 1);
      do @(posedge clk); while (prdy !== 1'b1);
      exp_q.push_back(bt(w, icmf_pkg::REC_IMAGE, 1'b0));
      for (int b = 31; b >= 0; b--) begin
        crc = (crc[31] ^ w[b]) ? ((crc << 1) ^ icmf_pkg::CRC_POLY) : (crc << 1);
      end
    end
    pv <= 1'b0;
    plast <= 1'b0;
  endtask

  // wait for the expected beat count, then compare in order
  task automatic check_rx();
    int k;
    k = 0;
    while (host_u.rx_q.size() < exp_q.size() && k < 2000) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk); // let stray extra beats land
    cmp32("beats", 32'(exp_q.size()), 32'(host_u.rx_q.size()));
    foreach (exp_q[i]) if (i < host_u.rx_q.size()) cmp_beat(exp_q[i], host_u.rx_q[i]);
    exp_q.delete();
    host_u.rx_q.delete();
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {psel, pen, pwr, acq, fs, ee, pv, plast, slow} = '0;
    paddr = '0;
    pwd = '0;
    pd = '0;
    lines = 8'h5A;
    meta = '0;
    meta.frame_num = 32'h0000_0010;
    meta.gain_g = 32'h0000_0C0D;
    meta.tstamp = 64'h1234_5678_9ABC_DEF0;
    meta.left = 16'h0012;
    meta.span_y = 16'h01E0;
    meta.shutter = 32'h0000_2710;
    meta.black = 32'h0000_0040;
    meta.pix = icmf_pkg::PIX_MONO12P;
    meta.step = 8'h03;
    meta.serial_len = 8'h04;
    meta.serial_data = 32'h4F4B_0D0A;
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and an unmapped place
    rd_chk("ctrl", icmf_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd_chk("stat", icmf_pkg::ADDR_STAT, 32'h0000_0000, 1'b0);
    rd_chk("ien", icmf_pkg::ADDR_IEN, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 8'h40, 32'h0000_0000, 1'b1);
    // image and check records cannot be dropped
    for (int r = 0; r < 2; r++) begin
      wr(icmf_pkg::ADDR_PICK, 32'(r));
      wr(icmf_pkg::ADDR_INCL, 32'h0000_0000);
      rd_chk("incl_fixed", icmf_pkg::ADDR_INCL, 32'h0000_0001, 1'b0);
    end
    // per record flags through the selector
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_FNUM));
    wr(icmf_pkg::ADDR_INCL, 32'h0000_0001);
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_GAIN));
    wr(icmf_pkg::ADDR_INCL, 32'h0000_0001);
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_TIME));
    wr(icmf_pkg::ADDR_INCL, 32'h0000_0001);
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_LEFT));
    rd_chk("incl_left", icmf_pkg::ADDR_INCL, 32'h0000_0000, 1'b0);
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_FNUM));
    rd_chk("incl_fnum", icmf_pkg::ADDR_INCL, 32'h0000_0001, 1'b0);
    // frame with attach off, host stalling: image and check only
    wr(icmf_pkg::ADDR_IEN, 32'h0000_0001);
    acq <= 1'b1;
    slow <= 1'b1;
    send_frame(3);
    exp_q.push_back(bt(crc, icmf_pkg::REC_CHECK, 1'b1));
    check_rx();
    rd_chk("crc_reg", icmf_pkg::ADDR_CRC, crc, 1'b0);
    rd_chk("fnum_reg", icmf_pkg::ADDR_FNUM, 32'h0000_0010, 1'b0);
    rd_chk("stat_done", icmf_pkg::ADDR_STAT, 32'h0000_0001, 1'b0);
    cmp32("irq_on", 32'h0000_0001, {31'h0000_0000, irq});
    wr(icmf_pkg::ADDR_CLR, 32'h0000_0001);
    cmp32("irq_off", 32'h0000_0000, {31'h0000_0000, irq});
    // include and attach changes while running are refused; the include write is also flagged
    wr(icmf_pkg::ADDR_PICK, 32'(icmf_pkg::REC_LEFT));
    wr(icmf_pkg::ADDR_INCL, 32'h0000_0001);
    rd_chk("incl_frozen", icmf_pkg::ADDR_INCL, 32'h0000_0000, 1'b0);
    rd_chk("stat_refused", icmf_pkg::ADDR_STAT, 32'h0000_0002, 1'b0);
    wr(icmf_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_chk("ctrl_frozen", icmf_pkg::ADDR_CTRL, 32'h0000_0002, 1'b0);
    // host stops acquisition before reconfiguring
    acq <= 1'b0;
    wr(icmf_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_chk("ctrl_attach", icmf_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
    wr(icmf_pkg::ADDR_CLR, 32'h0000_0007);
    wr(icmf_pkg::ADDR_GAINP, 32'h0000_0002);
    // every optional record on while acquisition is stopped
    for (int r = 3; r < icmf_pkg::NUM_REC; r++) begin
      wr(icmf_pkg::ADDR_PICK, 32'(r));
      wr(icmf_pkg::ADDR_INCL, 32'h0000_0001);
    end
    // exposure end snapshot, lines move on afterwards
    @(posedge clk) ee <= 1'b1;
    @(posedge clk) ee <= 1'b0;
    lines <= 8'hC3;
    // frame with records; metadata changes after start must not show
    meta.serial_ovr <= 1'b1;
    acq <= 1'b1;
    slow <= 1'b0;
    send_frame(2);
    exp_q.push_back(bt(crc, icmf_pkg::REC_CHECK, 1'b0));
    exp_q.push_back(bt(32'h0000_0011, icmf_pkg::REC_FNUM, 1'b0));
    exp_q.push_back(bt(32'h0000_0012, icmf_pkg::REC_LEFT, 1'b0));
    exp_q.push_back(bt(32'h0000_0000, icmf_pkg::REC_TOP, 1'b0));
    exp_q.push_back(bt(32'h0000_0000, icmf_pkg::REC_SPANX, 1'b0));
    exp_q.push_back(bt(32'h0000_01E0, icmf_pkg::REC_SPANY, 1'b0));
    exp_q.push_back(bt(32'h0000_2710, icmf_pkg::REC_SHUTTER, 1'b0));
    exp_q.push_back(bt(32'h0000_0C0D, icmf_pkg::REC_GAIN, 1'b0));
    exp_q.push_back(bt(32'h0000_0040, icmf_pkg::REC_BLACK, 1'b0));
    exp_q.push_back(bt(32'h0000_0001, icmf_pkg::REC_PIXEL, 1'b0));
    exp_q.push_back(bt(32'h9ABC_DEF0, icmf_pkg::REC_TIME, 1'b0));
    exp_q.push_back(bt(32'h1234_5678, icmf_pkg::REC_TIME, 1'b0));
    exp_q.push_back(bt(32'h0000_0003, icmf_pkg::REC_STEP, 1'b0));
    exp_q.push_back(bt(32'h0000_0104, icmf_pkg::REC_SERIAL, 1'b0));
    exp_q.push_back(bt(32'h4F4B_0D0A, icmf_pkg::REC_SERIAL, 1'b0));
    exp_q.push_back(bt(32'h0000_005A, icmf_pkg::REC_LINES, 1'b1));
    check_rx();
    rd_chk("stat_ovr", icmf_pkg::ADDR_STAT, 32'h0000_0005, 1'b0);
    wr(icmf_pkg::ADDR_IEN, 32'h0000_0000);
    cmp32("irq_masked", 32'h0000_0000, {31'h0000_0000, irq});
    give_verdict();
  end
endmodule // testbench
